// ---- hdl/fsa_flash_segment_access.sv ----
// Flash array with segment erase, byte/word programming, segment A
// lock, access and key violation flags and fetch range checking.
// Assumes CPU and debug requests are synchronous to i_sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "fsa_regs.svh"

module fsa_flash_segment_access #(
  parameter logic [63:0] OSC_CAL_VALUES = 64'h0000_0000_0000_0000
) (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_arst_n,
  input  wire logic                     i_cpu_req,
  input  wire logic                     i_cpu_we,
  input  wire logic                     i_cpu_byte,
  input  wire logic                     i_cpu_fetch,
  input  wire logic [15:0]              i_cpu_addr,
  input  wire logic [15:0]              i_cpu_wdata,
  input  wire logic                     i_dbg_we,
  input  wire logic                     i_dbg_byte,
  input  wire logic [15:0]              i_dbg_addr,
  input  wire logic [15:0]              i_dbg_wdata,
  input  wire logic                     i_erase_req,
  input  wire fsa_pkg::fsa_erase_mode_t i_erase_mode,
  input  wire logic [15:0]              i_erase_addr,
  input  wire logic                     i_ctl_wr,
  input  wire logic [7:0]               i_ctl_key,
  input  wire logic                     i_ctl_lock_a,
  input  wire logic                     i_access_violation_irq_enable,
  input  wire logic                     i_access_violation_clear,
  input  wire logic                     i_key_violation_clear,
  output logic [15:0]                   o_rdata,
  output logic                          o_rdata_valid,
  output logic                          o_seg_a_locked,
  output logic                          o_access_violation_flag,
  output logic                          o_flash_key_violation,
  output logic                          o_nmi_req,
  output logic                          o_sys_reset,
  output logic [15:0]                   o_vector_addr
);
  import fsa_pkg::*;

  localparam int MEM_BYTES = `FSA_MAIN_BYTES + `FSA_INFO_BYTES;
  localparam int IW        = `FSA_IDX_W;
  localparam int TAG_IDX   = `FSA_MAIN_BYTES +
                             int'(`FSA_OSC_TAG_ADDR - `FSA_INFO_BASE);

  // ****************************************************************
  // Address decoding
  // ****************************************************************
  function automatic logic in_main(input logic [15:0] a);
    return a >= `FSA_MAIN_BASE;
  endfunction
  function automatic logic in_info(input logic [15:0] a);
    return a >= `FSA_INFO_BASE && a <= `FSA_INFO_LAST;
  endfunction
  function automatic logic in_ram(input logic [15:0] a);
    return a >= `FSA_RAM_BASE && a <= `FSA_RAM_LAST;
  endfunction
  function automatic logic in_seg_a(input logic [15:0] a);
    return in_info(a) && a[7:6] == `FSA_INFO_SEG_A;
  endfunction

  // Main bytes sit first in the array, information bytes after them
  function automatic fsa_idx_t mem_index(input logic [15:0] a);
    fsa_idx_t idx;
    if (in_main(a)) begin
      idx = {1'b0, a[11:0]};
    end else begin
      idx = `FSA_INFO_IDX0 | {5'h00, a[7:0]};
    end
    return idx;
  endfunction

  // Power-up image: all erased except the calibration structure
  function automatic fsa_byte_t init_byte(input int unsigned idx);
    int unsigned a;
    fsa_byte_t   b;
    a = idx + 32'(`FSA_INFO_BASE) - `FSA_MAIN_BYTES;
    b = `FSA_ERASED;
    if (idx >= `FSA_MAIN_BYTES) begin
      if (a == 32'(`FSA_EMPTY_ADDR)) begin
        b = `FSA_EMPTY_TAG;
      end else if (a == 32'(`FSA_EMPTY_ADDR) + 1) begin
        b = `FSA_EMPTY_LEN;
      end else if (a == 32'(`FSA_OSC_TAG_ADDR)) begin
        b = `FSA_OSC_TAG;
      end else if (a == 32'(`FSA_OSC_TAG_ADDR) + 1) begin
        b = `FSA_OSC_LEN;
      end else if (a >= 32'(`FSA_OSC_TAG_ADDR) + 2) begin
        b = OSC_CAL_VALUES[(a - 32'(`FSA_OSC_TAG_ADDR) - 2) * 8 +: 8];
      end
    end
    return b;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  fsa_byte_t                  mem_r [MEM_BYTES];
  logic                       seg_a_locked_r;
  logic                       acc_flag_nxt;
  logic                       key_flag_nxt;
  logic [`FSA_MAIN_SEGS-1:0]  main_clr;
  logic [`FSA_INFO_SEGS-1:0]  info_clr;
  logic                       erase_hits_a;
  logic                       erase_blocked;
  logic                       erase_ok;
  logic                       wr_req;
  logic                       wr_byte;
  logic [15:0]                wr_addr;
  logic [15:0]                wr_data;
  logic                       wr_flash;
  logic                       wr_blocked;
  logic                       wr_ok;
  logic                       wr_lo_en;
  logic                       wr_hi_en;
  fsa_idx_t                   wr_base;
  fsa_idx_t                   wr_base_hi;
  fsa_byte_t                  wr_hi_data;
  fsa_idx_t                   rd_base;
  fsa_idx_t                   rd_base_hi;
  logic                       key_bad;
  logic                       fetch_bad;
  logic                       rst_nxt;
  logic                       nmi_nxt;

  assign o_seg_a_locked = seg_a_locked_r;

  // ****************************************************************
  // Erase decode
  // ****************************************************************
  // A whole-array erase while A is locked is refused entirely, so a
  // half-done erase never leaves main and info out of step.
  assign erase_hits_a  = (i_erase_mode == FSA_ERASE_ALL) ||
                         (i_erase_mode == FSA_ERASE_SEG &&
                          in_seg_a(i_erase_addr));
  assign erase_blocked = i_erase_req && seg_a_locked_r && erase_hits_a;
  assign erase_ok      = i_erase_req && !erase_blocked;

  always_comb begin
    for (int s = 0; s < `FSA_MAIN_SEGS; s++) begin
      main_clr[s] = erase_ok &&
        (i_erase_mode == FSA_ERASE_MAIN_ALL ||
         i_erase_mode == FSA_ERASE_ALL ||
         (i_erase_mode == FSA_ERASE_SEG && in_main(i_erase_addr) &&
          i_erase_addr[11:9] == 3'(s)));
    end
    for (int s = 0; s < `FSA_INFO_SEGS; s++) begin
      info_clr[s] = erase_ok &&
        (i_erase_mode == FSA_ERASE_ALL ||
         (i_erase_mode == FSA_ERASE_SEG && in_info(i_erase_addr) &&
          i_erase_addr[7:6] == 2'(s)));
    end
  end

  // ****************************************************************
  // Program decode
  // ****************************************************************
  // Debug port wins a same-cycle clash; the CPU write is dropped.
  assign wr_req  = i_dbg_we || (i_cpu_req && i_cpu_we);
  assign wr_byte = i_dbg_we ? i_dbg_byte  : i_cpu_byte;
  assign wr_addr = i_dbg_we ? i_dbg_addr  : i_cpu_addr;
  assign wr_data = i_dbg_we ? i_dbg_wdata : i_cpu_wdata;

  // An erase in the same cycle takes the array; the write is ignored
  assign wr_flash   = wr_req && !i_erase_req &&
                      (in_main(wr_addr) || in_info(wr_addr));
  assign wr_blocked = wr_flash && seg_a_locked_r && in_seg_a(wr_addr);
  assign wr_ok      = wr_flash && !wr_blocked;
  assign wr_base    = mem_index({wr_addr[15:1], 1'b0});
  assign wr_base_hi = wr_base + 1'b1;
  assign wr_lo_en   = wr_ok && (!wr_byte || !wr_addr[0]);
  assign wr_hi_en   = wr_ok && (!wr_byte || wr_addr[0]);
  assign wr_hi_data = wr_byte ? wr_data[7:0] : wr_data[15:8];

  // ****************************************************************
  // Array: one flip-flop byte per location
  // ****************************************************************
  // Programming can only clear bits, as a real cell does; only an
  // erase or the i_arst_n reload of the power-up image brings a bit back to one.
  for (genvar gi = 0; gi < MEM_BYTES; gi++) begin : g_byte
    logic clr;
    if (gi < `FSA_MAIN_BYTES) begin : g_main
      assign clr = main_clr[gi / `FSA_MAIN_SEG_BYTES];
    end else begin : g_info
      assign clr = info_clr[(gi - `FSA_MAIN_BYTES) / `FSA_INFO_SEG_BYTES];
    end
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        mem_r[gi] <= init_byte(gi);
      end else if (clr) begin
        mem_r[gi] <= `FSA_ERASED;
      end else if (wr_lo_en && wr_base == IW'(gi)) begin
        mem_r[gi] <= mem_r[gi] & wr_data[7:0];
      end else if (wr_hi_en && wr_base_hi == IW'(gi)) begin
        mem_r[gi] <= mem_r[gi] & wr_hi_data;
      end
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  assign rd_base    = mem_index({i_cpu_addr[15:1], 1'b0});
  assign rd_base_hi = rd_base + 1'b1;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata_valid <= 1'b0;
      o_rdata       <= 16'h0000;
    end else begin
      o_rdata_valid <= i_cpu_req && !i_cpu_we;
      if (in_main(i_cpu_addr) || in_info(i_cpu_addr)) begin
        o_rdata <= {mem_r[rd_base_hi], mem_r[rd_base]};
      end else begin
        o_rdata <= 16'h0000;
      end
    end
  end

  // ****************************************************************
  // Segment A lock
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      seg_a_locked_r <= 1'b1;
    end else if (rst_nxt) begin
      seg_a_locked_r <= 1'b1;
    end else if (i_ctl_wr) begin
      seg_a_locked_r <= i_ctl_lock_a;
    end
  end

  // ****************************************************************
  // Violations, reset and NMI requests
  // ****************************************************************
  assign key_bad   = i_ctl_wr && i_ctl_key != `FSA_CTL_KEY;
  // Only CPU fetches from RAM, information or main flash are legal
  assign fetch_bad = i_cpu_req && i_cpu_fetch &&
                     !(in_main(i_cpu_addr) || in_info(i_cpu_addr) ||
                       in_ram(i_cpu_addr));
  assign rst_nxt   = key_bad || fetch_bad;

  // Set wins over a same-cycle clear on both sticky flags
  assign acc_flag_nxt = wr_blocked || erase_blocked ||
                        (o_access_violation_flag &&
                         !i_access_violation_clear);
  assign key_flag_nxt = key_bad ||
                        (o_flash_key_violation && !i_key_violation_clear);
  // Global interrupt enable lives in the CPU and never reaches here
  assign nmi_nxt      = acc_flag_nxt && i_access_violation_irq_enable;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_access_violation_flag <= 1'b0;
      o_flash_key_violation   <= 1'b0;
      o_nmi_req               <= 1'b0;
    end else begin
      o_access_violation_flag <= acc_flag_nxt;
      o_flash_key_violation   <= key_flag_nxt;
      o_nmi_req               <= nmi_nxt;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sys_reset   <= 1'b0;
      o_vector_addr <= `FSA_VEC_RESET;
    end else begin
      o_sys_reset <= rst_nxt;
      if (rst_nxt) begin
        o_vector_addr <= `FSA_VEC_RESET;
      end else if (nmi_nxt) begin
        o_vector_addr <= `FSA_VEC_NMI;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_key_bad;
    i_ctl_wr && i_ctl_key != `FSA_CTL_KEY;
  endsequence
  sequence s_reset_out;
    o_sys_reset && o_vector_addr == `FSA_VEC_RESET && seg_a_locked_r;
  endsequence
  sequence s_seg_a_hit;
    wr_flash && seg_a_locked_r && in_seg_a(wr_addr);
  endsequence
  key_reset_out_a: assert property (
    s_key_bad |=> s_reset_out ##0 o_flash_key_violation)
    else $error("key violation did not raise reset");
  fetch_range_a: assert property (
    i_cpu_req && i_cpu_fetch && i_cpu_addr <= `FSA_PERIPH_LAST
    |=> s_reset_out)
    else $error("peripheral fetch did not reset");
  lock_flags_a: assert property (
    s_seg_a_hit |=> o_access_violation_flag)
    else $error("locked segment A write not flagged");
  lock_keeps_a: assert property (
    seg_a_locked_r |=> $stable(mem_r[TAG_IDX]))
    else $error("locked segment A changed");
  nmi_gate_a: assert property (
    o_nmi_req |-> o_access_violation_flag &&
                  $past(i_access_violation_irq_enable))
    else $error("nmi without flag or enable");
  word_write_a: assert property (
    wr_ok && !wr_byte && wr_base == 13'h0000
    |=> mem_r[0] == $past(mem_r[0] & wr_data[7:0]) &&
        mem_r[1] == $past(mem_r[1] & wr_data[15:8]))
    else $error("word write wrong");
  byte_write_a: assert property (
    wr_ok && wr_byte && wr_addr == 16'hF003 |=> $stable(mem_r[2]) &&
    mem_r[3] == $past(mem_r[3] & wr_data[7:0]))
    else $error("byte write touched neighbour");
  main_all_a: assert property (
    erase_ok && i_erase_mode == FSA_ERASE_MAIN_ALL
    |=> mem_r[0] == `FSA_ERASED && mem_r[4095] == `FSA_ERASED &&
        $stable(mem_r[TAG_IDX]))
    else $error("main erase wrong");
  main_seg_a: assert property (
    erase_ok && i_erase_mode == FSA_ERASE_SEG &&
    i_erase_addr == 16'hF3FF
    |=> mem_r[512] == `FSA_ERASED && $stable(mem_r[511]))
    else $error("main segment erase wrong");
  info_seg_a: assert property (
    erase_ok && i_erase_mode == FSA_ERASE_SEG &&
    i_erase_addr == 16'h107F
    |=> mem_r[4160] == `FSA_ERASED && $stable(mem_r[4096]) &&
        $stable(mem_r[4224]))
    else $error("info segment erase wrong");
  full_erase_a: assert property (
    erase_ok && i_erase_mode == FSA_ERASE_ALL
    |=> mem_r[TAG_IDX] == `FSA_ERASED && mem_r[0] == `FSA_ERASED)
    else $error("array erase wrong");

endmodule
`default_nettype wire

// ---- hdl/fsa_regs.svh ----
// Constants of the flash segment access block: address map, segment
// geometry, calibration image layout, key and vector addresses.
// Assumes a 16-bit byte address space and a single system clock.
`ifndef FSA_REGS_SVH
`define FSA_REGS_SVH

// ****************************************************************
// Address map
// ****************************************************************
`define FSA_PERIPH_LAST    16'h01FF
`define FSA_RAM_BASE       16'h0200
`define FSA_RAM_LAST       16'h02FF
`define FSA_INFO_BASE      16'h1000
`define FSA_INFO_LAST      16'h10FF
`define FSA_MAIN_BASE      16'hF000
`define FSA_VEC_RESET      16'hFFFE
`define FSA_VEC_NMI        16'hFFFC

// ****************************************************************
// Segment geometry
// ****************************************************************
`define FSA_MAIN_BYTES     4096
`define FSA_INFO_BYTES     256
`define FSA_MAIN_SEG_BYTES 512
`define FSA_MAIN_SEGS      8
`define FSA_INFO_SEG_BYTES 64
`define FSA_INFO_SEGS      4
`define FSA_INFO_SEG_A     2'h3
`define FSA_IDX_W          13
`define FSA_INFO_IDX0      13'h1000

// ****************************************************************
// Calibration image and keys
// ****************************************************************
`define FSA_ERASED         8'hFF
`define FSA_EMPTY_ADDR     16'h10C0
`define FSA_EMPTY_TAG      8'hFE
`define FSA_EMPTY_LEN      8'h34
`define FSA_OSC_TAG_ADDR   16'h10F6
`define FSA_OSC_TAG        8'h01
`define FSA_OSC_LEN        8'h08
`define FSA_CTL_KEY        8'hA5

`endif

// ---- hdl/fsa_pkg.sv ----
// Types shared by the flash segment access block.
// Assumes fsa_regs.svh is on the include path.
`include "fsa_regs.svh"

package fsa_pkg;
  typedef logic [7:0]            fsa_byte_t;
  typedef logic [`FSA_IDX_W-1:0] fsa_idx_t;
  typedef enum logic [1:0] {
    FSA_ERASE_SEG,
    FSA_ERASE_MAIN_ALL,
    FSA_ERASE_ALL
  } fsa_erase_mode_t;
endpackage

// ---- verification/fsa_host_model.sv ----
// CPU and debug-port stand-in that makes requests to the flash block.
// Assumes one request per call, driven at the next rising clock edge and taken at the one after.
`timescale 1ns/1ps
`default_nettype none

module fsa_host_model (
  input  wire logic        i_sys_clk,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_rdata_valid,
  output logic             o_cpu_req,
  output logic             o_cpu_we,
  output logic             o_cpu_byte,
  output logic             o_cpu_fetch,
  output logic [15:0]      o_cpu_addr,
  output logic [15:0]      o_cpu_wdata,
  output logic             o_dbg_we,
  output logic             o_dbg_byte,
  output logic [15:0]      o_dbg_addr,
  output logic [15:0]      o_dbg_wdata
);
  initial begin
    o_cpu_req   = 1'b0;
    o_cpu_we    = 1'b0;
    o_cpu_byte  = 1'b0;
    o_cpu_fetch = 1'b0;
    o_cpu_addr  = 16'h0000;
    o_cpu_wdata = 16'h0000;
    o_dbg_we    = 1'b0;
    o_dbg_byte  = 1'b0;
    o_dbg_addr  = 16'h0000;
    o_dbg_wdata = 16'h0000;
  end

  // Kind 0 read, 1 CPU write, 2 debug write, 3 fetch
  task automatic access(input logic [1:0] k, input logic [15:0] a,
                        input logic [15:0] dat, input logic b,
                        output logic [15:0] rd, output logic vld);
    @(posedge i_sys_clk);
    o_cpu_req   <= k != 2'h2;
    o_cpu_we    <= k == 2'h1;
    o_cpu_fetch <= k == 2'h3;
    o_cpu_byte  <= b;
    o_cpu_addr  <= a;
    o_cpu_wdata <= dat;
    o_dbg_we    <= k == 2'h2;
    o_dbg_byte  <= b;
    o_dbg_addr  <= a;
    o_dbg_wdata <= dat;
    @(posedge i_sys_clk);
    o_cpu_req   <= 1'b0;
    o_dbg_we    <= 1'b0;
    // Released lines change so a stale value cannot pass for a hold
    o_cpu_addr  <= ~a;
    o_dbg_addr  <= ~a;
    o_cpu_wdata <= ~dat;
    o_dbg_wdata <= ~dat;
    #1;
    rd  = i_rdata;
    vld = i_rdata_valid;
  endtask
endmodule

`default_nettype wire

// ---- verification/fsa_flash_segment_access_bench.sv ----
// Self-checking bench for the flash segment access block.
// Assumes fsa_host_model stands in for the CPU and the debug port.
`timescale 1ns/1ps
`default_nettype none

module fsa_flash_segment_access_bench;
  import fsa_pkg::*;
  logic            sys_clk, arst_n, cpu_req, cpu_we, cpu_byte, cpu_fetch;
  logic            dbg_we, dbg_byte, rdata_valid, erase_req, ctl_wr;
  logic            ctl_lock_a, irq_en, av_clear, kv_clear;
  logic [15:0]     cpu_addr, cpu_wdata, dbg_addr, dbg_wdata, rdata;
  logic [15:0]     erase_addr, vec;
  logic [7:0]      ctl_key;
  fsa_erase_mode_t erase_mode;
  logic            locked, av_flag, key_viol, nmi_req, sys_reset;
  int              err_total, compares;

  fsa_flash_segment_access #(
    .OSC_CAL_VALUES(64'h8877_6655_4433_2211)
  ) i_fsa_flash_segment_access (
    .i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_cpu_req(cpu_req),
    .i_cpu_we(cpu_we), .i_cpu_byte(cpu_byte), .i_cpu_fetch(cpu_fetch),
    .i_cpu_addr(cpu_addr), .i_cpu_wdata(cpu_wdata), .i_dbg_we(dbg_we),
    .i_dbg_byte(dbg_byte), .i_dbg_addr(dbg_addr),
    .i_dbg_wdata(dbg_wdata), .i_erase_req(erase_req),
    .i_erase_mode(erase_mode), .i_erase_addr(erase_addr),
    .i_ctl_wr(ctl_wr), .i_ctl_key(ctl_key), .i_ctl_lock_a(ctl_lock_a),
    .i_access_violation_irq_enable(irq_en),
    .i_access_violation_clear(av_clear),
    .i_key_violation_clear(kv_clear), .o_rdata(rdata),
    .o_rdata_valid(rdata_valid), .o_seg_a_locked(locked),
    .o_access_violation_flag(av_flag), .o_flash_key_violation(key_viol),
    .o_nmi_req(nmi_req), .o_sys_reset(sys_reset), .o_vector_addr(vec)
  );

  fsa_host_model i_fsa_host_model (
    .i_sys_clk(sys_clk), .i_rdata(rdata), .i_rdata_valid(rdata_valid),
    .o_cpu_req(cpu_req), .o_cpu_we(cpu_we), .o_cpu_byte(cpu_byte),
    .o_cpu_fetch(cpu_fetch), .o_cpu_addr(cpu_addr),
    .o_cpu_wdata(cpu_wdata), .o_dbg_we(dbg_we), .o_dbg_byte(dbg_byte),
    .o_dbg_addr(dbg_addr), .o_dbg_wdata(dbg_wdata)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic wrap_up();
    $display("mismatches %0d, comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask

  task automatic bchk(input string n, input logic e, input logic g);
    chk(n, {15'h0000, e}, {15'h0000, g});
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic        v;
    i_fsa_host_model.access(2'h0, a, 16'h0000, 1'b0, d, v);
    bchk("read valid", 1'b1, v);
    chk("read data", e, d);
  endtask

  task automatic wr(input logic [1:0] k, input logic [15:0] a,
                    input logic [15:0] dat, input logic b);
    logic [15:0] d;
    logic        v;
    i_fsa_host_model.access(k, a, dat, b, d, v);
  endtask

  task automatic erase(input fsa_erase_mode_t m, input logic [15:0] a);
    @(posedge sys_clk);
    erase_req  <= 1'b1;
    erase_mode <= m;
    erase_addr <= a;
    @(posedge sys_clk);
    erase_req  <= 1'b0;
    #1;
  endtask

  task automatic ctl(input logic [7:0] key, input logic lock);
    @(posedge sys_clk);
    ctl_wr     <= 1'b1;
    ctl_key    <= key;
    ctl_lock_a <= lock;
    @(posedge sys_clk);
    ctl_wr     <= 1'b0;
    #1;
  endtask

  task automatic clear_flags();
    @(posedge sys_clk);
    av_clear <= 1'b1;
    kv_clear <= 1'b1;
    @(posedge sys_clk);
    av_clear <= 1'b0;
    kv_clear <= 1'b0;
    #1;
    bchk("access flag", 1'b0, av_flag);
    bchk("key flag", 1'b0, key_viol);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_image();
    bchk("locked", 1'b1, locked);
    chk("vector", 16'hFFFE, vec);
    rd(16'h10F6, 16'h0801);
    rd(16'h10C0, 16'h34FE);
    rd(16'h10F8, 16'h2211);
    rd(16'h0200, 16'h0000);
    rd(16'hFFC0, 16'hFFFF);
  endtask

  task automatic t_program();
    wr(2'h1, 16'hF000, 16'h1234, 1'b0);
    rd(16'hF000, 16'h1234);
    wr(2'h1, 16'hF003, 16'h0056, 1'b1);
    rd(16'hF002, 16'h56FF);
    wr(2'h2, 16'hF010, 16'h00AB, 1'b1);
    rd(16'hF010, 16'hFFAB);
  endtask

  task automatic t_erase_main();
    wr(2'h1, 16'hF200, 16'h0000, 1'b0);
    wr(2'h1, 16'hF3FE, 16'h0000, 1'b0);
    wr(2'h1, 16'hF400, 16'h0000, 1'b0);
    erase(FSA_ERASE_SEG, 16'hF3FF);
    rd(16'hF200, 16'hFFFF);
    rd(16'hF3FE, 16'hFFFF);
    rd(16'hF400, 16'h0000);
    rd(16'hF000, 16'h1234);
    wr(2'h1, 16'h1000, 16'h0000, 1'b0);
    erase(FSA_ERASE_MAIN_ALL, 16'h0000);
    rd(16'hF000, 16'hFFFF);
    rd(16'hF400, 16'hFFFF);
    rd(16'h1000, 16'h0000);
    wr(2'h1, 16'h1040, 16'h0000, 1'b0);
    wr(2'h1, 16'h1080, 16'h0000, 1'b0);
    erase(FSA_ERASE_SEG, 16'h107F);
    rd(16'h1040, 16'hFFFF);
    rd(16'h1000, 16'h0000);
    rd(16'h1080, 16'h0000);
  endtask

  task automatic t_lock();
    @(posedge sys_clk);
    irq_en <= 1'b1;
    wr(2'h1, 16'h10F6, 16'h0000, 1'b0);
    bchk("access flag", 1'b1, av_flag);
    bchk("nmi", 1'b1, nmi_req);
    chk("vector", 16'hFFFC, vec);
    rd(16'h10F6, 16'h0801);
    clear_flags();
    bchk("nmi", 1'b0, nmi_req);
    erase(FSA_ERASE_SEG, 16'h10C0);
    bchk("access flag", 1'b1, av_flag);
    rd(16'h10C0, 16'h34FE);
    clear_flags();
    @(posedge sys_clk);
    irq_en <= 1'b0;
    erase(FSA_ERASE_ALL, 16'h0000);
    bchk("access flag", 1'b1, av_flag);
    bchk("nmi", 1'b0, nmi_req);
    rd(16'h1000, 16'h0000);
    clear_flags();
    // Segment A is erased only after a deliberate unlock
    ctl(8'hA5, 1'b0);
    bchk("locked", 1'b0, locked);
    wr(2'h1, 16'h10C0, 16'h0000, 1'b0);
    wr(2'h1, 16'hF600, 16'h0000, 1'b0);
    rd(16'h10C0, 16'h0000);
    erase(FSA_ERASE_ALL, 16'h0000);
    bchk("access flag", 1'b0, av_flag);
    rd(16'h10C0, 16'hFFFF);
    rd(16'h1080, 16'hFFFF);
    rd(16'hF600, 16'hFFFF);
    ctl(8'hA5, 1'b1);
    bchk("locked", 1'b1, locked);
  endtask

  task automatic t_key();
    ctl(8'hA5, 1'b0);
    ctl(8'h00, 1'b0);
    bchk("reset pulse", 1'b1, sys_reset);
    bchk("key flag", 1'b1, key_viol);
    bchk("locked", 1'b1, locked);
    chk("vector", 16'hFFFE, vec);
    @(posedge sys_clk);
    #1;
    bchk("reset pulse", 1'b0, sys_reset);
    clear_flags();
  endtask

  task automatic t_fetch();
    logic [15:0] fa [8];
    logic [7:0]  hit;
    logic [15:0] d;
    logic        v;
    fa  = '{16'h0100, 16'h01FF, 16'h0300, 16'h0FFE,
            16'h0200, 16'h02FE, 16'h1000, 16'hF000};
    hit = 8'h0F;
    for (int i = 0; i < 8; i++) begin
      i_fsa_host_model.access(2'h3, fa[i], 16'h0000, 1'b0, d, v);
      bchk("fetch reset", hit[i], sys_reset);
    end
  endtask

  // ****************************************************************
  // Clock, run and watchdog
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    $display("unexpected run length: expected end, seen timeout");
    wrap_up();
  end

  initial begin
    err_total  = 0;
    compares   = 0;
    arst_n     = 1'b0;
    erase_req  = 1'b0;
    erase_mode = FSA_ERASE_SEG;
    erase_addr = 16'h0000;
    ctl_wr     = 1'b0;
    ctl_key    = 8'h00;
    ctl_lock_a = 1'b1;
    irq_en     = 1'b0;
    av_clear   = 1'b0;
    kv_clear   = 1'b0;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    #1;
    t_image();
    t_program();
    t_erase_main();
    t_lock();
    t_key();
    t_fetch();
    wrap_up();
  end
endmodule

`default_nettype wire
